// [src/rsi_reset_state.sv]
// Reset initial state logic with AXI4-Lite register access
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rsi_consts.svh"
module rsi_reset_state (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset events from the generators
  input wire rsi_pkg::rsi_rst_req_t rst_req,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // State driven into the core
  output logic [7:0] pc_low,
  output logic [2:0] stack_ptr,
  output logic [7:0] int_ctrl,
  output logic [7:0] port_data,
  output logic [7:0] port_dir,
  output logic timers_on,
  output logic irq
);
  import rsi_pkg::*;

  // Reset priority is power-on, then low voltage, then watchdog. The
  // sleep watchdog is a warm reset: it keeps almost all state, so
  // software tells it apart by the timeout and powerdown flags and by its interrupt status bit.
  // Register writes that meet a reset event in one cycle are dropped, save those
  // to the interrupt status and mask; all are still answered on the bus.

  // Register file
  logic [7:0] pcl_q, status_q, intc_q, pa_q, pac_q, watchdog_control_q, low_voltage_select_q, acc_q;
  logic [3:0] rstf_q;
  logic [2:0] sp_q;
  logic tmr_q;
  logic [15:0] wdcnt_q;
  // Event and interrupt state
  logic [3:0] ist_q, imsk_q;
  logic [3:0] ist_clr, ist_set;
  logic irq_q;
  // Bus channel state
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] bresp_q, rresp_q;
  // Readies are flops holding the inverse of the hold flags, and of rvalid for reads
  logic awready_q, wready_q, arready_q;
  // Reset classification
  rsi_src_t src;
  logic any_rst, wr_fire, full_rst;

  // Classify the incoming reset; power-on takes priority
  always_comb begin
    src = RSI_SRC_POR;
    any_rst = 1'b1;
    if (!aresetn || rst_req.por) begin
      src = RSI_SRC_POR;
    end else if (rst_req.low_voltage_reset) begin
      src = RSI_SRC_LVR;
    end else if (rst_req.wdt && rst_req.idle) begin
      src = RSI_SRC_WDS;
    end else if (rst_req.wdt) begin
      src = RSI_SRC_WDN;
    end else begin
      any_rst = 1'b0;
    end
  end

  // Byte-lane merge for register writes
  function automatic logic [7:0] merge8(input logic [7:0] old,
      input logic [31:0] d, input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction

  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

  // Full resets reload defaults; the sleep watchdog only clears a few
  assign full_rst = any_rst && src != RSI_SRC_WDS;

  // A register write, save to the interrupt status and mask, lands only when no reset event shares the cycle,
  // so a reset can never be undone by a write in flight
  function automatic logic wr_hit(input logic [7:0] addr);
    wr_hit = wr_fire && !any_rst && awaddr_q == addr;
  endfunction

  // Write address capture; its ready is the inverse of the hold flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awready_q <= 1'b1;
      awaddr_q <= 8'h00;
    end else if (s_awvalid && !aw_hold_q) begin
      aw_hold_q <= 1'b1;
      awready_q <= 1'b0;
      awaddr_q <= s_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  // Write data capture, apart from the address so either may lead
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wready_q <= 1'b1;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_wvalid && !w_hold_q) begin
      w_hold_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q <= s_wdata;
      wstrb_q <= s_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  // A write dropped for a reset still gets its answer, so the master
  // never hangs on a response that was lost to the reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q > `RSI_OFF_WDCNT || awaddr_q[1:0] != 2'b00) ?
        2'b10 : 2'b00;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Program counter low byte: every reset source clears it, so the
  // core always restarts from the first address
  always_ff @(posedge aclk) begin
    if (any_rst) begin
      pcl_q <= `RSI_RST_PCL;
    end else if (wr_hit(`RSI_OFF_PCL)) begin
      pcl_q <= merge8(pcl_q, wdata_q, wstrb_q);
    end
  end

  // Timeout and powerdown flags; the other status bits are plain
  // storage that software owns and no reset touches
  always_ff @(posedge aclk) begin
    if (any_rst) begin
      case (src)
        RSI_SRC_POR: begin
          status_q[`RSI_TO_BIT] <= 1'b0;
          status_q[`RSI_PDF_BIT] <= 1'b0;
        end
        RSI_SRC_LVR: begin
          // Both flags kept as they were
          status_q <= status_q;
        end
        RSI_SRC_WDN: begin
          status_q[`RSI_TO_BIT] <= 1'b1;
        end
        RSI_SRC_WDS: begin
          status_q[`RSI_TO_BIT] <= 1'b1;
          status_q[`RSI_PDF_BIT] <= 1'b1;
        end
        default: begin
          status_q <= status_q;
        end
      endcase
    end else if (wr_hit(`RSI_OFF_STATUS)) begin
      status_q <= merge8(status_q, wdata_q, wstrb_q);
    end
  end

  // Reset source flags: hardware sets only the low-voltage flag, software only clears them;
  // a set in the same cycle as a clear wins because resets come first
  always_ff @(posedge aclk) begin
    if (any_rst && src == RSI_SRC_POR) begin
      rstf_q <= 4'h0; // Unknown flag cleared too
    end else if (any_rst && src == RSI_SRC_LVR) begin
      rstf_q[`RSI_LVRF_BIT] <= 1'b1;
    end else if (wr_hit(`RSI_OFF_RSTF) && wstrb_q[0]) begin
      rstf_q <= rstf_q & wdata_q[3:0];
    end
  end

  // Interrupt enables: every source off after a full reset, so no
  // stale enable can fire before software has set things up
  always_ff @(posedge aclk) begin
    if (full_rst) begin
      intc_q <= `RSI_RST_INTERRUPT_CONTROL_0;
    end else if (wr_hit(`RSI_OFF_INTERRUPT_CONTROL_0)) begin
      intc_q <= merge8(intc_q, wdata_q, wstrb_q);
    end
  end

  // Port data and direction all ones, so every pin comes up an input;
  // the sleep watchdog keeps whatever software had set
  always_ff @(posedge aclk) begin
    if (full_rst) begin
      pa_q <= `RSI_RST_PA;
      pac_q <= `RSI_RST_PAC;
    end else begin
      if (wr_hit(`RSI_OFF_PA)) begin
        pa_q <= merge8(pa_q, wdata_q, wstrb_q);
      end
      if (wr_hit(`RSI_OFF_PAC)) begin
        pac_q <= merge8(pac_q, wdata_q, wstrb_q);
      end
    end
  end

  // Watchdog control back to its default on every full reset
  always_ff @(posedge aclk) begin
    if (full_rst) begin
      watchdog_control_q <= `RSI_RST_WATCHDOG_CONTROL;
    end else if (wr_hit(`RSI_OFF_WATCHDOG_CONTROL)) begin
      watchdog_control_q <= merge8(watchdog_control_q, wdata_q, wstrb_q);
    end
  end

  // Voltage select survives low-voltage and sleep watchdog resets, so
  // a brown-out does not lose the threshold software chose
  always_ff @(posedge aclk) begin
    if (any_rst && (src == RSI_SRC_POR || src == RSI_SRC_WDN)) begin
      low_voltage_select_q <= `RSI_RST_LOW_VOLTAGE_SELECT;
    end else if (wr_hit(`RSI_OFF_LOW_VOLTAGE_SELECT)) begin
      low_voltage_select_q <= merge8(low_voltage_select_q, wdata_q, wstrb_q);
    end
  end

  // Stack pointer and timer enable share the control word; every
  // reset sends the stack pointer to the top, only full ones stop timers
  always_ff @(posedge aclk) begin
    if (any_rst) begin
      sp_q <= `RSI_RST_STACK_TOP;
      if (full_rst) begin
        tmr_q <= 1'b0;
      end
    end else if (wr_hit(`RSI_OFF_CTRL) && wstrb_q[0]) begin
      tmr_q <= wdata_q[0];
      sp_q <= wdata_q[3:1];
    end
  end

  // Accumulator is never reset
  always_ff @(posedge aclk) begin
    if (wr_hit(`RSI_OFF_ACC) && wstrb_q[0]) begin
      acc_q <= wdata_q[7:0];
    end
  end

  // Watchdog counter restarts on any full reset and counts at once;
  // sixteen bits wrap silently, the count only shows liveness
  always_ff @(posedge aclk) begin
    if (full_rst) begin
      wdcnt_q <= 16'h0000;
    end else begin
      wdcnt_q <= wdcnt_q + 16'h0001;
    end
  end

  // Clear and set masks for the sticky event bits
  assign ist_clr = (wr_fire && awaddr_q == `RSI_OFF_IRQ_ST && wstrb_q[0]) ?
    wdata_q[3:0] : 4'h0;
  assign ist_set = any_rst ? 4'(src) : 4'h0;

  // Sticky event bits, one per reset source; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q <= 4'h0;
    end else begin
      ist_q <= (ist_q & ~ist_clr) | ist_set;
    end
  end

  // Interrupt mask, written by software only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imsk_q <= 4'h0;
    end else if (wr_fire && awaddr_q == `RSI_OFF_IRQ_MSK && wstrb_q[0]) begin
      imsk_q <= wdata_q[3:0];
    end
  end

  // Interrupt output registered; a cycle of latency buys a clean pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ist_q & imsk_q);
    end
  end

  // Read channel; one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
      arready_q <= 1'b1;
    end else if (s_arvalid && !rvalid_q) begin
      // Unaligned or unmapped addresses fall to the default arm
      rvalid_q <= 1'b1;
      arready_q <= 1'b0;
      rresp_q <= 2'b00;
      case (s_araddr)
        `RSI_OFF_PCL: rdata_q <= {24'h00_0000, pcl_q};
        `RSI_OFF_STATUS: rdata_q <= {24'h00_0000, status_q};
        `RSI_OFF_RSTF: rdata_q <= {28'h000_0000, rstf_q};
        `RSI_OFF_INTERRUPT_CONTROL_0: rdata_q <= {24'h00_0000, intc_q};
        `RSI_OFF_PA: rdata_q <= {24'h00_0000, pa_q};
        `RSI_OFF_PAC: rdata_q <= {24'h00_0000, pac_q};
        `RSI_OFF_WATCHDOG_CONTROL: rdata_q <= {24'h00_0000, watchdog_control_q};
        `RSI_OFF_LOW_VOLTAGE_SELECT: rdata_q <= {24'h00_0000, low_voltage_select_q};
        `RSI_OFF_ACC: rdata_q <= {24'h00_0000, acc_q};
        `RSI_OFF_CTRL: rdata_q <= {28'h000_0000, sp_q, tmr_q};
        `RSI_OFF_IRQ_ST: rdata_q <= {28'h000_0000, ist_q};
        `RSI_OFF_IRQ_MSK: rdata_q <= {28'h000_0000, imsk_q};
        `RSI_OFF_WDCNT: rdata_q <= {16'h0000, wdcnt_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= 2'b10;
        end
      endcase
    end else if (s_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Ready drops while a channel holds its item: one write in flight
  assign s_awready = awready_q;
  assign s_wready = wready_q;
  assign s_arready = arready_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;
  // Core state pins, each straight from its register
  assign pc_low = pcl_q;
  assign stack_ptr = sp_q;
  assign int_ctrl = intc_q;
  assign port_data = pa_q;
  assign port_dir = pac_q;
  assign timers_on = tmr_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// [src/rsi_consts.svh]
// Constants for the reset initial state block
// What this block does
// - Low-voltage reset keeps timeout and powerdown flags
// - Normal watchdog reset sets timeout, keeps powerdown
// - Sleep watchdog reset sets both flags
// - Flags live in status; power-on clears both
// - Power-on disables every interrupt
// - Power-on clears the watchdog counter
// - Power-on switches all timers off
// - Power-on sets port data/direction to ones
// - Power-on: stack pointer top, counter zero
// - Defaults loaded; sleep watchdog keeps them and counter
// - Low-voltage keeps accumulator, select; sets flag
// - Sleep watchdog zeroes program counter and stack pointer
`ifndef RSI_CONSTS_SVH
`define RSI_CONSTS_SVH
`define RSI_OFF_PCL 8'h00
`define RSI_OFF_STATUS 8'h04
`define RSI_OFF_RSTF 8'h08
`define RSI_OFF_INTERRUPT_CONTROL_0 8'h0C
`define RSI_OFF_PA 8'h10
`define RSI_OFF_PAC 8'h14
`define RSI_OFF_WATCHDOG_CONTROL 8'h18
`define RSI_OFF_LOW_VOLTAGE_SELECT 8'h1C
`define RSI_OFF_ACC 8'h20
`define RSI_OFF_CTRL 8'h24
`define RSI_OFF_IRQ_ST 8'h28
`define RSI_OFF_IRQ_MSK 8'h2C
`define RSI_OFF_WDCNT 8'h30
`define RSI_TO_BIT 5
`define RSI_PDF_BIT 4
`define RSI_LVRF_BIT 2
`define RSI_RST_PCL 8'h00
`define RSI_RST_INTERRUPT_CONTROL_0 8'h00
`define RSI_RST_PA 8'hFF
`define RSI_RST_PAC 8'hFF
`define RSI_RST_WATCHDOG_CONTROL 8'h53
`define RSI_RST_LOW_VOLTAGE_SELECT 8'h66
`define RSI_RST_STACK_TOP 3'h0
`endif

// [src/rsi_pkg.sv]
// Types for the reset initial state block
package rsi_pkg;
  typedef enum logic [3:0] {
    RSI_SRC_POR = 4'b0001,
    RSI_SRC_LVR = 4'b0010,
    RSI_SRC_WDN = 4'b0100,
    RSI_SRC_WDS = 4'b1000
  } rsi_src_t;
  typedef struct packed {
    logic por;
    logic low_voltage_reset;
    logic wdt;
    logic idle;
  } rsi_rst_req_t;
endpackage

// [verification/rsi_reset_state_chk.sv]
// Checker for the reset initial state block
`timescale 1ns/1ns
`default_nettype none
module rsi_reset_state_chk
  import rsi_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire rsi_pkg::rsi_rst_req_t rst_req,
  // Bus handshakes
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // Core state
  input wire logic [7:0] pc_low,
  input wire logic [2:0] stack_ptr,
  input wire logic [7:0] int_ctrl,
  input wire logic [7:0] port_data,
  input wire logic [7:0] port_dir,
  input wire logic timers_on
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // State that every full reset must load
  sequence s_defaults;
    pc_low == 8'h00 && stack_ptr == 3'h0 && int_ctrl == 8'h00 &&
    port_data == 8'hff && port_dir == 8'hff && !timers_on;
  endsequence
  // Address and data taken at one edge
  sequence s_wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  a_por_state: assert property (rst_req.por |=> s_defaults)
    else $error("power-on state wrong");
  a_lvr_state: assert property (
    rst_req.low_voltage_reset && !rst_req.por |=> s_defaults)
    else $error("low-voltage state wrong");
  a_wdn_state: assert property (
    rst_req.wdt && !rst_req.idle && !rst_req.por && !rst_req.low_voltage_reset
    |=> s_defaults) else $error("watchdog state wrong");
  // Sleep watchdog clears only the program counter low byte and stack pointer
  a_sleep_keep: assert property (
    rst_req.wdt && rst_req.idle && !rst_req.por && !rst_req.low_voltage_reset |=>
    pc_low == 8'h00 && stack_ptr == 3'h0 && $stable(int_ctrl) &&
    $stable(port_data) && $stable(port_dir) && $stable(timers_on))
    else $error("sleep watchdog state wrong");
  a_write_answer: assert property (s_wr_taken |-> ##2 s_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_bvalid_drop: assert property (s_bvalid && s_bready |=> !s_bvalid)
    else $error("write answer repeated");
  a_rvalid_drop: assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read answer repeated");
endmodule
bind rsi_reset_state rsi_reset_state_chk chk_u (.aclk(aclk),
  .aresetn(aresetn), .rst_req(rst_req), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .pc_low(pc_low), .stack_ptr(stack_ptr), .int_ctrl(int_ctrl),
  .port_data(port_data), .port_dir(port_dir), .timers_on(timers_on));
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the reset initial state block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import rsi_pkg::*;
  logic aclk = '0, aresetn = '0, s_awvalid = '0, s_wvalid = '0;
  logic s_bready = '0, s_arvalid = '0, s_rready = '0, s_awready, s_wready;
  logic s_bvalid, s_arready, s_rvalid, timers_on, irq, ta, tw, tr, tb, iq;
  logic [7:0] s_awaddr = '0, s_araddr = '0, pc_low, int_ctrl;
  logic [7:0] port_data, port_dir;
  logic [31:0] s_wdata = '0, s_rdata, rd;
  logic [3:0] s_wstrb = 4'hf;
  logic [1:0] s_bresp, s_rresp, rr;
  logic [2:0] stack_ptr;
  rsi_rst_req_t rst_req = '0;
  int miscompares = 0, n_checks = 0;
  localparam logic [35:0] def_pins = {8'h00, 3'h0, 8'h00, 8'hff, 8'hff, 1'b0};
  // Reads after power-on: address, mask, expected
  logic [23:0] rows [8] = '{24'h00_ff00, 24'h04_3000, 24'h0c_ff00,
    24'h10_ffff, 24'h14_ffff, 24'h18_ff53, 24'h1c_ff66, 24'h24_0f00};

  // Free-running clock
  initial forever #4 aclk = ~aclk;

  rsi_reset_state dut_u (.aclk(aclk), .aresetn(aresetn), .rst_req(rst_req),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .pc_low(pc_low),
    .stack_ptr(stack_ptr), .int_ctrl(int_ctrl), .port_data(port_data),
    .port_dir(port_dir), .timers_on(timers_on), .irq(irq));

  task automatic chk(string n, logic [35:0] e, logic [35:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // Handshakes are sampled mid-cycle, after the registered readies have updated
  task automatic wr(logic [7:0] a, logic [31:0] d);
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      {ta, tw, tb} = {s_awready, s_wready, s_bvalid};
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      if (tb) begin
        s_bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    miscompares++;
    tally_and_finish;
  endtask

  task automatic rdr(logic [7:0] a);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'b11;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      {ta, tr, rr, rd} = {s_arready, s_rvalid, s_rresp, s_rdata};
      @(posedge aclk);
      if (ta) s_arvalid <= 1'b0;
      if (tr) begin
        s_rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    miscompares++;
    tally_and_finish;
  endtask

  task automatic rchk(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    rdr(a);
    chk($sformatf("reg %h", a), e, rd & m);
  endtask

  task automatic pins(logic [35:0] e);
    @(negedge aclk);
    chk("pins", e,
      {pc_low, stack_ptr, int_ctrl, port_data, port_dir, timers_on});
    @(posedge aclk);
  endtask

  // One-cycle reset event, then let the registered state land
  task automatic pulse(rsi_rst_req_t r);
    rst_req <= r;
    @(posedge aclk);
    rst_req <= '0;
    @(posedge aclk);
  endtask

  task automatic sirq;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    iq = irq;
    @(posedge aclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    pins(def_pins);
    foreach (rows[i])
      rchk(rows[i][23:16], rows[i][15:8], rows[i][7:0]);
    // Non-default values, so kept and reloaded state differ
    wr(8'h00, 32'h12);
    wr(8'h0c, 32'h5a);
    wr(8'h10, 32'h3c);
    wr(8'h14, 32'h0f);
    wr(8'h24, 32'h0b);
    wr(8'h1c, 32'h55);
    pulse(4'b0011);
    pins({8'h00, 3'h0, 8'h5a, 8'h3c, 8'h0f, 1'b1});
    rchk(8'h04, 32'h30, 32'h30);
    rchk(8'h1c, 32'hff, 32'h55);
    pulse(4'b0100);
    pins(def_pins);
    rchk(8'h04, 32'h30, 32'h30);
    rchk(8'h08, 32'h04, 32'h04);
    rchk(8'h1c, 32'hff, 32'h55);
    pulse(4'b1000);
    rchk(8'h30, 32'hfff0, 32'h0);
    rchk(8'h04, 32'h30, 32'h00);
    rchk(8'h1c, 32'hff, 32'h66);
    wr(8'h1c, 32'h55);
    pulse(4'b0010);
    rchk(8'h04, 32'h30, 32'h20);
    rchk(8'h1c, 32'hff, 32'h66);
    pulse(4'b0100);
    rchk(8'h04, 32'h30, 32'h20);
    // Every event is pending now, so only the mask moves irq
    wr(8'h2c, 32'h0);
    sirq;
    chk("irq masked", 36'h0, {35'h0, iq});
    wr(8'h2c, 32'hf);
    sirq;
    chk("irq mask", 36'h1, {35'h0, iq});
    wr(8'h28, 32'hf);
    rchk(8'h28, 32'hf, 32'h0);
    sirq;
    chk("irq clear", 36'h0, {35'h0, iq});
    // Unmapped address is refused
    rdr(8'hfc);
    chk("resp", 36'h2, {34'h0, rr});
    chk("rdata", 36'h0, {4'h0, rd});
    tally_and_finish;
  end
endmodule
`default_nettype wire
